// file: memory_cycle_defs.vh
`ifndef MEMORY_CYCLE_DEFS_VH
`define MEMORY_CYCLE_DEFS_VH

// ****************************************
// Timing
// ****************************************
`define CLOCK_PERIOD_NS 50
`define STATE_TIME_NS 400
`define STATE_CYCLES ((`STATE_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

// ****************************************
// Memory select codes
// ****************************************
`define MEM_S 2'h0
`define MEM_T 2'h1
`define MEM_VFF 2'h2
`define MEM_VT 2'h3

// ****************************************
// Instruction class codes
// ****************************************
`define CLASS_A 2'h0
`define CLASS_B 2'h1
`define CLASS_C 2'h2

// ****************************************
// Counter time states
// ****************************************
`define ST_00 5'h00
`define ST_01 5'h01
`define ST_02 5'h02
`define ST_03 5'h03
`define ST_04 5'h04
`define ST_05 5'h05
`define ST_06 5'h06
`define ST_09 5'h09
`define ST_10 5'h0A
`define ST_11 5'h0B
`define ST_13 5'h0D
`define ST_14 5'h0E
`define ST_15 5'h0F
`define ST_16 5'h10
`define ST_21 5'h15
`define ST_22 5'h16
`define ST_23 5'h17
`define ST_24 5'h18
`define ST_25 5'h19
`define ST_31 5'h1F

`endif

// file: instr_path_table.v
`timescale 1ns/1ps
`default_nettype none
`include "memory_cycle_defs.vh"

module instr_path_table (
   input wire [4:0] state_in,
   input wire [1:0] mem_in,
   input wire final_cycle_in,
   output reg [4:0] next_state_out
);

   // ****************************************
   // Next memory-cycle state, hop or skip
   // ****************************************
   always @* begin
      next_state_out = `ST_00;
      case (state_in)
         `ST_00: next_state_out = `ST_01;
         `ST_01: next_state_out = final_cycle_in ? `ST_09 : `ST_02;
         `ST_02: next_state_out = (mem_in == `MEM_VFF) ? `ST_09 : `ST_03;
         `ST_03: next_state_out = (mem_in == `MEM_S) ? `ST_04 : `ST_09;
         `ST_04: next_state_out = `ST_05;
         `ST_05: next_state_out = `ST_06;
         `ST_06: next_state_out = `ST_09;
         `ST_14: begin
            // Faster memories skip to 22 early
            if (!final_cycle_in && (mem_in == `MEM_T || mem_in == `MEM_VT))
               next_state_out = `ST_22;
            else
               next_state_out = `ST_15;
         end
         `ST_15: begin
            if (!final_cycle_in && mem_in == `MEM_S)
               next_state_out = `ST_16;
            else
               next_state_out = `ST_22;
         end
         `ST_16: next_state_out = `ST_22;
         default: begin
            if (state_in >= `ST_09 && state_in < `ST_14)
               next_state_out = state_in + 5'h01;
            else
               next_state_out = `ST_00;
         end
      endcase
   end

endmodule
`default_nettype wire

// file: operand_path_table.v
`timescale 1ns/1ps
`default_nettype none
`include "memory_cycle_defs.vh"

module operand_path_table (
   input wire [4:0] state_in,
   input wire [1:0] mem_in,
   input wire extend_in,
   output reg [4:0] next_state_out
);

   // ****************************************
   // Next operand state, extension in middle
   // ****************************************
   always @* begin
      next_state_out = `ST_00;
      case (state_in)
         `ST_00: next_state_out = `ST_01;
         `ST_01: next_state_out = `ST_02;
         `ST_02: next_state_out = (mem_in == `MEM_T) ? `ST_09 : `ST_03;
         `ST_03: next_state_out = (mem_in == `MEM_S) ? `ST_04 : `ST_09;
         `ST_04: next_state_out = `ST_05;
         `ST_05: next_state_out = `ST_06;
         `ST_06: next_state_out = `ST_09;
         `ST_09: next_state_out = `ST_10;
         `ST_10: next_state_out = `ST_11;
         `ST_11: next_state_out = `ST_13;
         `ST_13: begin
            if (extend_in)
               next_state_out = `ST_24;
            else if (mem_in != `MEM_T)
               next_state_out = `ST_14;
            else
               next_state_out = `ST_21;
         end
         `ST_14: next_state_out = `ST_21;
         `ST_24: next_state_out = `ST_25;
         `ST_25: next_state_out = (mem_in != `MEM_T) ? `ST_14 : `ST_21;
         `ST_21: next_state_out = `ST_22;
         `ST_22: next_state_out = `ST_23;
         `ST_23: next_state_out = `ST_31;
         default: next_state_out = `ST_00;
      endcase
   end

endmodule
`default_nettype wire

// file: memory_cycle_sequencer.v
`timescale 1ns/1ps
`default_nettype none
`include "memory_cycle_defs.vh"

module memory_cycle_sequencer (
   input wire clock_in,
   input wire reset_in,
   input wire start_request_in,
   input wire deferred_address_flag_in,
   input wire [1:0] instr_mem_in,
   input wire [1:0] operand_mem_in,
   input wire [1:0] instr_class_in,
   input wire has_operand_in,
   input wire operand_load_class_flag_in,
   input wire complement_memory_instr_in,
   input wire insert_instr_in,
   input wire no_overlap_in,
   input wire sequence_change_in,
   input wire decision_pending_in,
   input wire delay_sync_busy_in,
   input wire execute_wait_in,
   input wire operand_wait_in,
   output reg [4:0] instr_cycle_counter_out,
   output reg [4:0] operand_cycle_counter_out,
   output reg instr_running_out,
   output reg operand_running_out,
   output reg operand_busy_interlock_out,
   output reg abandon_out,
   output reg state_step_out
);

   // ****************************************
   // Time step
   // ****************************************
   localparam integer STATE_CYCLES = `STATE_CYCLES;
   localparam [31:0] STEP_LAST = STATE_CYCLES - 1;

   function is_v_memory;
      input [1:0] mem;
      begin
         is_v_memory = mem[1];
      end
   endfunction

   function is_flipflop_memory;
      input [1:0] mem;
      begin
         is_flipflop_memory = (mem == `MEM_VFF);
      end
   endfunction

   reg [3:0] step_count;
   wire step_tick;

   // Every state lasts one or more fixed steps; counters move only on the tick
   assign step_tick = (step_count == STEP_LAST[3:0]);

   // Inputs act only on a tick; hold them as levels
   always @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         step_count <= 4'h0;
         state_step_out <= 1'b0;
      end else begin
         state_step_out <= step_tick;
         if (step_tick)
            step_count <= 4'h0;
         else
            step_count <= step_count + 4'h1;
      end
   end

   // ****************************************
   // Latched cycle context
   // ****************************************
   reg [1:0] fetch_mem;
   reg [1:0] fetch_class;
   reg fetch_final;
   reg fetch_has_operand;
   reg [1:0] op_mem;
   reg op_extend;
   reg op_pending;
   reg [1:0] pend_mem;
   reg pend_extend;

   wire [4:0] instr_table_next;
   wire [4:0] operand_table_next;
   wire overlap_allowed;
   wire instr_may_start;
   wire operand_may_start;
   wire modify_or_non_load;
   wire now_extend;

   // ****************************************
   // Path lookups
   // ****************************************

   instr_path_table instr_table (
      .state_in(instr_cycle_counter_out),
      .mem_in(fetch_mem),
      .final_cycle_in(fetch_final),
      .next_state_out(instr_table_next)
   );

   operand_path_table operand_table (
      .state_in(operand_cycle_counter_out),
      .mem_in(op_mem),
      .extend_in(op_extend),
      .next_state_out(operand_table_next)
   );

   // ****************************************
   // Start interlocks
   // ****************************************

   // Different memories overlap unless the interlock flag says no
   // Live inputs: operand memory must stay steady while busy
   assign overlap_allowed = !no_overlap_in &&
      (instr_mem_in != operand_mem_in);

   // Operand busy stalls the next fetch when overlap is barred
   // Waiting operand stalls it too: one overlap at most
   assign instr_may_start = start_request_in && !instr_running_out &&
      !op_pending &&
      (!operand_busy_interlock_out || overlap_allowed);

   // Operand waits at rest until fetch has handed over at 24
   assign operand_may_start = op_pending && !operand_running_out &&
      !operand_busy_interlock_out;

   // Non-load S or T, and modify instructions, lengthen operand
   assign modify_or_non_load = complement_memory_instr_in ||
      insert_instr_in ||
      (!operand_load_class_flag_in && !is_v_memory(operand_mem_in));
   assign now_extend = modify_or_non_load;

   // ****************************************
   // Instruction counter
   // ****************************************
   reg [4:0] next_instr_state;
   reg next_instr_running;
   reg next_abandon;
   reg reach_24;

   always @* begin
      next_instr_state = instr_cycle_counter_out;
      next_instr_running = instr_running_out;
      next_abandon = 1'b0;
      reach_24 = 1'b0;
      if (!instr_running_out) begin
         if (instr_may_start && step_tick) begin
            next_instr_running = 1'b1;
            next_instr_state = `ST_00;
         end
      end else if (step_tick) begin
         case (instr_cycle_counter_out)
            `ST_02: begin
               if (is_flipflop_memory(fetch_mem) && !fetch_final &&
                   sequence_change_in) begin
                  next_instr_state = `ST_00;
                  next_instr_running = 1'b0;
                  next_abandon = 1'b1;
               end else begin
                  next_instr_state = instr_table_next;
               end
            end
            `ST_22: begin
               if (sequence_change_in) begin
                  next_instr_state = `ST_00;
                  next_instr_running = 1'b0;
                  next_abandon = 1'b1;
               end else if (decision_pending_in) begin
                  next_instr_state = `ST_23;
               end else begin
                  next_instr_state = `ST_24;
                  reach_24 = 1'b1;
               end
            end
            `ST_23: begin
               // Held while delay-sync cycles examine interlocks
               if (delay_sync_busy_in || decision_pending_in) begin
                  next_instr_state = `ST_23;
               end else if (sequence_change_in) begin
                  next_instr_state = `ST_00;
                  next_instr_running = 1'b0;
                  next_abandon = 1'b1;
               end else begin
                  next_instr_state = `ST_24;
                  reach_24 = 1'b1;
               end
            end
            `ST_24: begin
               // Class C finishes here, A and B execute 25 to 31
               if (fetch_class == `CLASS_C) begin
                  next_instr_state = `ST_00;
                  next_instr_running = 1'b0;
               end else begin
                  next_instr_state = `ST_25;
               end
            end
            `ST_25: begin
               if (execute_wait_in)
                  next_instr_state = `ST_25;
               else
                  next_instr_state = instr_cycle_counter_out + 5'h01;
            end
            `ST_31: begin
               next_instr_state = `ST_00;
               next_instr_running = 1'b0;
            end
            default: begin
               if (instr_cycle_counter_out > `ST_25)
                  next_instr_state = instr_cycle_counter_out + 5'h01;
               else
                  next_instr_state = instr_table_next;
            end
         endcase
      end
   end

   always @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         instr_cycle_counter_out <= `ST_00;
         instr_running_out <= 1'b0;
         abandon_out <= 1'b0;
         fetch_mem <= `MEM_S;
         fetch_class <= `CLASS_C;
         fetch_final <= 1'b0;
         fetch_has_operand <= 1'b0;
      end else begin
         instr_cycle_counter_out <= next_instr_state;
         instr_running_out <= next_instr_running;
         abandon_out <= next_abandon;
         if (!instr_running_out && next_instr_running) begin
            fetch_mem <= instr_mem_in;
            fetch_class <= instr_class_in;
            fetch_final <= deferred_address_flag_in;
            // Class A never calls for an operand
            fetch_has_operand <= has_operand_in &&
               (instr_class_in != `CLASS_A);
         end
      end
   end

   // ****************************************
   // Operand hand-over
   // ****************************************
   always @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         op_pending <= 1'b0;
         pend_mem <= `MEM_S;
         pend_extend <= 1'b0;
      end else if (reach_24 && fetch_has_operand) begin
         // Captured at 24 so operand starts only as its own fetch leaves 24
         op_pending <= 1'b1;
         pend_mem <= operand_mem_in;
         pend_extend <= now_extend;
      end else if (operand_may_start && step_tick) begin
         op_pending <= 1'b0;
      end
   end

   // ****************************************
   // Operand counter
   // ****************************************
   reg [4:0] next_operand_state;
   reg next_operand_running;
   reg next_busy;

   always @* begin
      next_operand_state = operand_cycle_counter_out;
      next_operand_running = operand_running_out;
      next_busy = operand_busy_interlock_out;
      if (!operand_running_out) begin
         if (operand_may_start && step_tick) begin
            next_operand_running = 1'b1;
            next_operand_state = `ST_00;
            next_busy = 1'b1;
         end
      end else if (step_tick) begin
         case (operand_cycle_counter_out)
            `ST_03: begin
               // Only the accumulator can hold the operand here
               if (operand_wait_in && is_flipflop_memory(op_mem))
                  next_operand_state = `ST_03;
               else
                  next_operand_state = operand_table_next;
            end
            `ST_31: begin
               next_operand_state = `ST_00;
               next_operand_running = 1'b0;
               next_busy = 1'b0;
            end
            default: next_operand_state = operand_table_next;
         endcase
      end
   end

   always @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         operand_cycle_counter_out <= `ST_00;
         operand_running_out <= 1'b0;
         operand_busy_interlock_out <= 1'b0;
         op_mem <= `MEM_S;
         op_extend <= 1'b0;
      end else begin
         operand_cycle_counter_out <= next_operand_state;
         operand_running_out <= next_operand_running;
         operand_busy_interlock_out <= next_busy;
         if (!operand_running_out && next_operand_running) begin
            op_mem <= pend_mem;
            op_extend <= pend_extend;
         end
      end
   end

endmodule
`default_nettype wire

// file: seq_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Sequencer checks
// ****
module seq_checker (
   input wire logic clock_in,
   input wire logic reset_in,
   input wire logic [1:0] instr_mem_in,
   input wire logic [1:0] operand_mem_in,
   input wire logic no_overlap_in,
   input wire logic [4:0] instr_cycle_counter_out,
   input wire logic [4:0] operand_cycle_counter_out,
   input wire logic instr_running_out,
   input wire logic operand_busy_interlock_out,
   input wire logic abandon_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (reset_in);
   wire [4:0] pc = instr_cycle_counter_out;
   wire [4:0] qc = operand_cycle_counter_out;
   // Fetch may start while busy only across two memories
   wire ovl_ok = !operand_busy_interlock_out ||
      (!no_overlap_in && instr_mem_in != operand_mem_in);
   a_reset_rest: assert property (disable iff (1'b0)
      reset_in |=> pc == 5'h00 && qc == 5'h00)
      else $error("counters not resting in reset");
   a_step_hold: assert property ($changed(pc) |=> $stable(pc) [*7])
      else $error("fetch state moved twice in one step");
   a_s_skip: assert property ($changed(pc) && $past(pc) == 5'h06
      |-> pc == 5'h09) else $error("state 06 not followed by 09");
   a_s_to_22: assert property ($changed(pc) && $past(pc) == 5'h10
      |-> pc == 5'h16) else $error("state 16 not followed by 22");
   a_jump_forward: assert property ($changed(pc) && pc != 5'h00
      |-> pc > $past(pc)) else $error("fetch state moved backward");
   a_abandon_pulse: assert property ($changed(pc) && pc == 5'h00 &&
      ($past(pc) == 5'h02 || $past(pc) == 5'h16 || $past(pc) == 5'h17)
      |-> ##[0:2] abandon_out) else $error("abandon without pulse");
   a_operand_end: assert property ($changed(qc) && qc == 5'h00
      |-> $past(qc) == 5'h1F) else $error("operand cycle not ended in 31");
   a_no_overlap: assert property ($rose(instr_running_out)
      |-> $past(ovl_ok)) else $error("fetch overlapped same memory");
   c_abandon: cover property (abandon_out);
   c_wait_23: cover property (pc == 5'h17);
   c_extend: cover property (qc == 5'h19);
endmodule

bind memory_cycle_sequencer seq_checker chk (
   .clock_in(clock_in),
   .reset_in(reset_in),
   .instr_mem_in(instr_mem_in),
   .operand_mem_in(operand_mem_in),
   .no_overlap_in(no_overlap_in),
   .instr_cycle_counter_out(instr_cycle_counter_out),
   .operand_cycle_counter_out(operand_cycle_counter_out),
   .instr_running_out(instr_running_out),
   .operand_busy_interlock_out(operand_busy_interlock_out),
   .abandon_out(abandon_out)
);
`default_nettype wire

// file: exec_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Execution side model
// ****
module exec_model (
   input wire logic clock_in,
   input wire logic reset_in,
   input wire logic slow_in,
   input wire logic [4:0] instr_state_in,
   input wire logic [4:0] operand_state_in,
   output logic execute_wait_out,
   output logic operand_wait_out,
   output logic pending_out,
   output logic sync_busy_out
);
   logic [5:0] held;
   wire at_25 = instr_state_in == 5'h19;
   wire at_dec = instr_state_in == 5'h16 || instr_state_in == 5'h17;
   wire at_03 = operand_state_in == 5'h03;
   // Slow mode holds each wait point for 20 clocks
   wire slow_now = slow_in && held < 6'h14;
   always @(posedge clock_in or posedge reset_in) begin
      if (reset_in) held <= 6'h00;
      else if (!(at_25 || at_dec || at_03)) held <= 6'h00;
      else if (held != 6'h3F) held <= held + 6'h01;
   end
   assign execute_wait_out = slow_now && at_25;
   assign operand_wait_out = slow_now && at_03;
   assign pending_out = slow_now && at_dec;
   assign sync_busy_out = slow_now && at_dec;
endmodule
`default_nettype wire

// file: memory_cycle_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "memory_cycle_defs.vh"
// ****
// Bench
// ****
module memory_cycle_sequencer_tb;
   logic clock_in = 1'b0;
   logic reset_in = 1'b1;
   logic start = 1'b0, deferred = 1'b0, has_op = 1'b0, load = 1'b1;
   logic complement_memory_instr = 1'b0, insert_instr = 1'b0, no_ovl = 1'b0, seq_chg = 1'b0, slow = 1'b0;
   logic [1:0] imem = 2'h0, omem = 2'h0, cls = 2'h2;
   wire [4:0] pc, qc;
   wire prun, qrun, busy, abandon, ewait, owait, pend, dbusy, step;
   int err_count = 0, num_checks = 0, rises = 0, aborts = 0, ovl = 0, cyc = 0;
   int steps = 0, gap = 0, bad_gap = 0;
   logic [4:0] ip[$], oq[$], ex[$], ep;
   logic pr = 1'b0, qr = 1'b0;
   logic [4:0] eq;

   memory_cycle_sequencer dut (
      .clock_in(clock_in), .reset_in(reset_in),
      .start_request_in(start), .deferred_address_flag_in(deferred),
      .instr_mem_in(imem), .operand_mem_in(omem), .instr_class_in(cls),
      .has_operand_in(has_op), .operand_load_class_flag_in(load),
      .complement_memory_instr_in(complement_memory_instr), .insert_instr_in(insert_instr),
      .no_overlap_in(no_ovl), .sequence_change_in(seq_chg),
      .decision_pending_in(pend), .delay_sync_busy_in(dbusy),
      .execute_wait_in(ewait), .operand_wait_in(owait),
      .instr_cycle_counter_out(pc), .operand_cycle_counter_out(qc),
      .instr_running_out(prun), .operand_running_out(qrun),
      .operand_busy_interlock_out(busy), .abandon_out(abandon),
      .state_step_out(step)
   );
   exec_model far (
      .clock_in(clock_in), .reset_in(reset_in), .slow_in(slow),
      .instr_state_in(pc), .operand_state_in(qc),
      .execute_wait_out(ewait), .operand_wait_out(owait),
      .pending_out(pend), .sync_busy_out(dbusy)
   );

   initial forever #25 clock_in = ~clock_in;

   // Paths are logged from pre-edge values, so no race
   always @(posedge clock_in) begin
      cyc++;
      if (prun === 1'b1 && (pr !== 1'b1 || pc !== ep)) ip.push_back(pc);
      if (qrun === 1'b1 && (qr !== 1'b1 || qc !== eq)) oq.push_back(qc);
      if (prun === 1'b1 && pr !== 1'b1) rises++;
      if (prun === 1'b1 && pr !== 1'b1 && busy === 1'b1) ovl++;
      if (abandon === 1'b1) aborts++;
      if (step === 1'b1) begin
         if (steps > 0 && gap != `STATE_CYCLES) bad_gap++;
         steps++;
         gap = 0;
      end
      gap++;
      pr = prun; ep = pc; qr = qrun; eq = qc;
      if (cyc == 60000) begin
         err_count++;
         complete_run;
      end
   end

   task check_path(input logic [4:0] got[$], input string what);
      int bad;
      begin
         bad = (got.size() != ex.size());
         foreach (got[i]) if (i < ex.size() && got[i] !== ex[i]) bad = 1;
         num_checks++;
         if (bad) begin
            err_count++;
            $display("[FAIL] %0t %s path wrong", $time, what);
         end
      end
   endtask
   task check_cnt(input int got, input int exp, input string what);
      begin
         num_checks++;
         if (got != exp) begin
            err_count++;
            $display("[FAIL] %0t %s count %0d", $time, what, got);
         end
      end
   endtask
   task add(input int lo, input int hi);
      for (int s = lo; s <= hi; s++) ex.push_back(s[4:0]);
   endtask
   // Hold the request until n fetches start, then wait for a quiet spell
   task go(input int n);
      int r0, i, j;
      begin
         ip = {}; oq = {}; ex = {}; aborts = 0; ovl = 0;
         r0 = rises; start = 1'b1; i = 0; j = 0;
         while (rises < r0 + n && i < 2000) begin
            @(posedge clock_in); #5; i++;
         end
         start = 1'b0;
         if (rises < r0 + n) begin
            err_count++;
            $display("[FAIL] %0t fetch never started", $time);
         end
         while (j < 16 && i < 4000) begin
            @(posedge clock_in); #5; i++;
            j = ((prun | qrun) === 1'b0) ? j + 1 : 0;
         end
         if (j < 16) begin
            err_count++;
            $display("[FAIL] %0t counters never came to rest", $time);
         end
      end
   endtask
   task complete_run;
      begin
         $display("checks %0d errors %0d", num_checks, err_count);
         if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask

   task t_fetch_paths;
      begin
         imem = `MEM_S; go(1);
         add(0, 6); add(9, 16); add(22, 22); add(24, 24);
         check_path(ip, "S fetch");
         imem = `MEM_VFF; go(1);
         add(0, 2); add(9, 15); add(22, 22); add(24, 24);
         check_path(ip, "acc fetch");
         imem = `MEM_S; deferred = 1'b1; go(1); deferred = 1'b0;
         add(0, 1); add(9, 15); add(22, 22); add(24, 24);
         check_path(ip, "final deferred");
         check_cnt(bad_gap + (steps < 2), 0, "step spacing");
      end
   endtask
   task t_abandon;
      begin
         seq_chg = 1'b1; imem = `MEM_VFF; go(1); add(0, 2);
         check_path(ip, "abandon at 02");
         check_cnt(aborts, 1, "abandon 02");
         imem = `MEM_T; go(1); add(0, 3); add(9, 14); add(22, 22);
         check_path(ip, "abandon at 22");
         check_cnt(aborts, 1, "abandon 22");
         seq_chg = 1'b0;
      end
   endtask
   task t_wait_class_a;
      begin
         imem = `MEM_VT; cls = `CLASS_A; slow = 1'b1; go(1);
         add(0, 3); add(9, 14); add(22, 31);
         check_path(ip, "wait 23 class A");
         cls = `CLASS_C; slow = 1'b0;
      end
   endtask
   task t_late_change;
      begin
         imem = `MEM_T; slow = 1'b1;
         fork
            go(1);
            begin
               wait (pc === 5'h17);
               @(posedge clock_in);
               #5 seq_chg = 1'b1;
            end
         join
         seq_chg = 1'b0; slow = 1'b0;
         add(0, 3); add(9, 14); add(22, 23);
         check_path(ip, "abandon at 23");
         check_cnt(aborts, 1, "abandon 23");
      end
   endtask
   task t_operands;
      begin
         imem = `MEM_S; omem = `MEM_VFF; has_op = 1'b1; slow = 1'b1; go(1);
         add(0, 6); add(9, 16); add(22, 24);
         check_path(ip, "load fetch");
         ex = {}; add(0, 3); add(9, 11); add(13, 14); add(21, 23); add(31, 31);
         check_path(oq, "acc operand");
         imem = `MEM_VFF; omem = `MEM_S; load = 1'b0; go(1);
         add(0, 6); add(9, 11); add(13, 13); add(24, 25); add(14, 14);
         add(21, 23); add(31, 31);
         check_path(oq, "extended S operand");
         load = 1'b1; slow = 1'b0; cls = `CLASS_B;
         imem = `MEM_S; omem = `MEM_T; go(1);
         add(0, 6); add(9, 16); add(22, 22); add(24, 31);
         check_path(ip, "class B fetch");
         ex = {}; add(0, 2); add(9, 11); add(13, 13); add(21, 23); add(31, 31);
         check_path(oq, "T operand");
         cls = `CLASS_C;
      end
   endtask
   task t_overlap;
      begin
         imem = `MEM_VFF; omem = `MEM_S; insert_instr = 1'b1; go(2);
         check_cnt(ovl != 0, 1, "split overlap");
         insert_instr = 1'b0; imem = `MEM_S; go(2);
         check_cnt(ovl, 0, "shared overlap");
         imem = `MEM_VFF; no_ovl = 1'b1; go(2);
         check_cnt(ovl, 0, "no overlap flag");
         no_ovl = 1'b0; has_op = 1'b0;
      end
   endtask

   initial begin
      repeat (2) @(posedge clock_in);
      #5 reset_in = 1'b0;
      t_fetch_paths;
      t_abandon;
      t_wait_class_a;
      t_late_change;
      t_operands;
      t_overlap;
      complete_run;
   end
endmodule
`default_nettype wire
